// ---- scr_pkg.sv ----
/*
  Shared constants, types and helpers for the serial control target with repeater
  forwarding. Assumes nothing of its surroundings; every user names items with scr_pkg::.
*/
package scr_pkg;

  // ---------------------------------------------------------------------------
  // Target address selection
  // ---------------------------------------------------------------------------

  // Number of strap positions and the address that each one selects.
  localparam int STRAP_COUNT = 10;
  localparam logic [6:0] STRAP_ADDR [STRAP_COUNT] = '{
    7'h2C, 7'h33, 7'h34, 7'h35, 7'h36, 7'h37, 7'h38, 7'h39, 7'h3A, 7'h3B
  };

  // ---------------------------------------------------------------------------
  // Register index map and field positions
  // ---------------------------------------------------------------------------

  localparam logic [7:0] REG_ID_IDX = 8'h00;
  localparam int ID_OVR_BIT = 0;
  localparam logic [7:0] ALIAS_BASE_IDX = 8'h08;
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [6:0] ALIAS_OFF = 7'h00;

  // ---------------------------------------------------------------------------
  // Protocol engine states
  // ---------------------------------------------------------------------------

  typedef enum logic [3:0] {
    S_IDLE, S_ADDR, S_RX, S_ACK, S_TX, S_HACK, S_FWD_ADDR, S_FWD_WR, S_FWD_RD
  } scr_state_t;

  // Maps a digitised strap position to its address; out-of-range picks the first.
  function automatic logic [6:0] strap_addr(input logic [3:0] sel);
    logic [6:0] res;
    res = STRAP_ADDR[0];
    if (int'(sel) < STRAP_COUNT) begin
      res = STRAP_ADDR[int'(sel)];
    end
    return res;
  endfunction : strap_addr

endpackage : scr_pkg

// ---- scr_line_if.sv ----
/*
  Bus-line event bundle passed from the line detector to the protocol engine.
  Assumes one clock domain; every event is a one-cycle pulse on sys_clk_i.
*/
`timescale 1ns/100ps
interface scr_line_if;
  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  logic sda;

  modport det (output scl_rise, output scl_fall, output start, output stop, output sda);
  modport eng (input scl_rise, input scl_fall, input start, input stop, input sda);
endinterface : scr_line_if

// ---- scr_line_det.sv ----
/*
  Synchronises the SCL and SDA pins and decodes edges, START and STOP.
  Assumes pins are asynchronous to sys_clk_i and the clock is much faster than SCL.
*/
`timescale 1ns/100ps
module scr_line_det (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  scr_line_if.det ev
);

  // ---------------------------------------------------------------------------
  // Synchronisers and delayed copies
  // ---------------------------------------------------------------------------

  logic [1:0] scl_sync_r;
  logic [1:0] sda_sync_r;
  logic scl_d_r;
  logic sda_d_r;

  // Two stages per pin, then one more stage for edge detection; idle bus is high.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_sync_r <= 2'h3;
      sda_sync_r <= 2'h3;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_sync_r <= {scl_sync_r[0], scl_i};
      sda_sync_r <= {sda_sync_r[0], sda_i};
      scl_d_r <= scl_sync_r[1];
      sda_d_r <= sda_sync_r[1];
    end
  end

  // ---------------------------------------------------------------------------
  // Event decode
  // ---------------------------------------------------------------------------

  // SDA falling with SCL high opens a frame, SDA rising with SCL high closes it.
  assign ev.sda = sda_sync_r[1];
  assign ev.scl_rise = scl_sync_r[1] & ~scl_d_r;
  assign ev.scl_fall = ~scl_sync_r[1] & scl_d_r;
  assign ev.start = scl_sync_r[1] & scl_d_r & sda_d_r & ~sda_sync_r[1];
  assign ev.stop = scl_sync_r[1] & scl_d_r & ~sda_d_r & sda_sync_r[1];

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  a_start_shape: assert property (ev.start |-> $past(ev.sda) && !ev.sda && $past(scl_sync_r[1]))
    else $error("START seen without SDA falling under high SCL.");
  a_stop_shape: assert property (ev.stop |-> !$past(ev.sda) && ev.sda && $past(scl_sync_r[1]))
    else $error("STOP seen without SDA rising under high SCL.");

endmodule : scr_line_det

// ---- scr_target.sv ----
/*
  Serial control target with register file, address aliasing and transparent
  forwarding over the back channel link. Assumes the link side answers each
  forwarding request with one done pulse on sys_clk_i, and the host honours stretching.
*/
`timescale 1ns/100ps
// Notes on behaviour
// - Strap picks one of ten addresses.
// - Detect START and STOP from SDA under SCL.
// - START opens a frame, STOP closes it.
// - Acknowledge own address, release on mismatch.
// - Acknowledge every written data byte held here; a forwarded one only when the link answers without NACK.
// - Lines are only pulled low or released.
// - Repeater forwards transactions over the link.
// - Alias address replaced by real downstream address.
// - Override bit selects address from register zero.
module scr_target #(
  parameter int REG_DEPTH = 16,
  parameter int NUM_ALIAS = 4
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_n_o,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_n_o,
  input wire logic [3:0] address_strap_pin_i,
  input wire logic repeat_mode_i,
  input wire logic downstream_irq_input_n_i,
  output logic downstream_irq_o,
  output logic back_channel_link_start_o,
  output logic back_channel_link_wr_o,
  output logic back_channel_link_rd_o,
  output logic back_channel_link_stop_o,
  output logic [6:0] back_channel_link_addr_o,
  output logic back_channel_link_rnw_o,
  output logic [7:0] back_channel_link_wdata_o,
  input wire logic back_channel_link_done_i,
  input wire logic back_channel_link_nack_i,
  input wire logic [7:0] back_channel_link_rdata_i
);

  localparam int IW = $clog2(REG_DEPTH);

  // ---------------------------------------------------------------------------
  // Line events and pin synchronisers
  // ---------------------------------------------------------------------------

  scr_line_if ev ();

  scr_line_det u_det (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .ev(ev)
  );

  logic [3:0] strap_s1_r;
  logic [3:0] strap_s2_r;
  logic [1:0] rep_s_r;
  logic [1:0] irq_s_r;

  // Strap, mode and interrupt pins pass two stages before any logic sees them.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strap_s1_r <= 4'h0;
      strap_s2_r <= 4'h0;
      rep_s_r <= 2'h0;
      irq_s_r <= 2'h3;
    end else begin
      strap_s1_r <= address_strap_pin_i;
      strap_s2_r <= strap_s1_r;
      rep_s_r <= {rep_s_r[0], repeat_mode_i};
      irq_s_r <= {irq_s_r[0], downstream_irq_input_n_i};
    end
  end

  // ---------------------------------------------------------------------------
  // State and decode
  // ---------------------------------------------------------------------------

  scr_pkg::scr_state_t state_r;
  logic [7:0] regs_r [REG_DEPTH];
  logic [3:0] cnt_r;
  logic [7:0] sh_r;
  logic [7:0] idx_r;
  logic rnw_r;
  logic first_r;
  logic fwd_r;
  logic host_ack_r;
  logic [6:0] own_addr;
  logic own_hit;
  logic alias_hit;
  logic [6:0] alias_real;
  logic alias_go;
  logic byte_end;
  logic wr_en;
  logic load_rd;
  logic [7:0] rd_data;

  // Own address comes from the strap unless register zero overrides it.
  assign own_addr = regs_r[0][scr_pkg::ID_OVR_BIT] ? regs_r[0][7:1]
                  : scr_pkg::strap_addr(strap_s2_r);
  assign own_hit = (sh_r[7:1] == own_addr);
  assign alias_go = rep_s_r[1] & alias_hit & ~own_hit;
  assign byte_end = ev.scl_fall & (cnt_r == 4'h8);
  assign wr_en = (state_r == scr_pkg::S_RX) & byte_end & ~fwd_r & ~first_r;
  assign load_rd = ev.scl_fall & (((state_r == scr_pkg::S_ACK) & rnw_r) | ((state_r == scr_pkg::S_HACK) & host_ack_r));
  assign rd_data = (idx_r == scr_pkg::REG_ID_IDX) ? {own_addr, regs_r[0][scr_pkg::ID_OVR_BIT]}
                 : regs_r[idx_r[IW-1:0]];

  // Alias table: even entry holds the alias, odd entry the real address.
  always_comb begin
    alias_hit = 1'b0;
    alias_real = scr_pkg::ALIAS_OFF;
    for (int k = 0; k < NUM_ALIAS; k++) begin
      if (regs_r[int'(scr_pkg::ALIAS_BASE_IDX) + 2*k][7:1] != scr_pkg::ALIAS_OFF &&
          regs_r[int'(scr_pkg::ALIAS_BASE_IDX) + 2*k][7:1] == sh_r[7:1]) begin
        alias_hit = 1'b1;
        alias_real = regs_r[int'(scr_pkg::ALIAS_BASE_IDX) + 2*k + 1][7:1];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------------------

  // Each written data byte after the index byte lands at the current index.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < REG_DEPTH; i++) begin
        regs_r[i] <= scr_pkg::REG_RESET;
      end
    end else if (wr_en) begin
      regs_r[idx_r[IW-1:0]] <= sh_r;
    end
  end

  // ---------------------------------------------------------------------------
  // Protocol engine
  // ---------------------------------------------------------------------------

  // Shifts in on SCL rise, shifts out and changes SDA on SCL fall; STOP and START take priority.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_r <= scr_pkg::S_IDLE;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      idx_r <= 8'h00;
      rnw_r <= 1'b0;
      first_r <= 1'b0;
      fwd_r <= 1'b0;
      host_ack_r <= 1'b0;
      sda_oe_n_o <= 1'b1;
      scl_oe_n_o <= 1'b1;
      back_channel_link_start_o <= 1'b0;
      back_channel_link_wr_o <= 1'b0;
      back_channel_link_rd_o <= 1'b0;
      back_channel_link_stop_o <= 1'b0;
      back_channel_link_addr_o <= 7'h00;
      back_channel_link_rnw_o <= 1'b0;
      back_channel_link_wdata_o <= 8'h00;
    end else begin
      back_channel_link_start_o <= 1'b0;
      back_channel_link_wr_o <= 1'b0;
      back_channel_link_rd_o <= 1'b0;
      back_channel_link_stop_o <= 1'b0;
      if (ev.stop) begin
        state_r <= scr_pkg::S_IDLE;
        sda_oe_n_o <= 1'b1;
        scl_oe_n_o <= 1'b1;
        back_channel_link_stop_o <= fwd_r;
        fwd_r <= 1'b0;
      end else if (ev.start) begin
        state_r <= scr_pkg::S_ADDR;
        cnt_r <= 4'h0;
        sda_oe_n_o <= 1'b1;
      end else begin
        unique case (state_r)
          scr_pkg::S_IDLE: begin
          end
          scr_pkg::S_ADDR, scr_pkg::S_RX: begin
            if (ev.scl_rise) begin
              sh_r <= {sh_r[6:0], ev.sda};
              cnt_r <= cnt_r + 4'h1;
            end else if (byte_end) begin
              cnt_r <= 4'h0;
              if (state_r == scr_pkg::S_ADDR) begin
                rnw_r <= sh_r[0];
                first_r <= 1'b1;
                if (own_hit) begin
                  sda_oe_n_o <= 1'b0;
                  state_r <= scr_pkg::S_ACK;
                  back_channel_link_stop_o <= fwd_r;
                  fwd_r <= 1'b0;
                end else if (alias_go) begin
                  fwd_r <= 1'b1;
                  back_channel_link_start_o <= 1'b1;
                  back_channel_link_addr_o <= alias_real;
                  back_channel_link_rnw_o <= sh_r[0];
                  scl_oe_n_o <= 1'b0;
                  state_r <= scr_pkg::S_FWD_ADDR;
                end else begin
                  state_r <= scr_pkg::S_IDLE;
                  back_channel_link_stop_o <= fwd_r;
                  fwd_r <= 1'b0;
                end
              end else if (fwd_r) begin
                back_channel_link_wr_o <= 1'b1;
                back_channel_link_wdata_o <= sh_r;
                scl_oe_n_o <= 1'b0;
                state_r <= scr_pkg::S_FWD_WR;
              end else begin
                sda_oe_n_o <= 1'b0;
                state_r <= scr_pkg::S_ACK;
                first_r <= 1'b0;
                idx_r <= first_r ? sh_r : idx_r + 8'h01;
              end
            end
          end
          scr_pkg::S_FWD_ADDR, scr_pkg::S_FWD_WR: begin
            // SCL is held low until the far end answers.
            if (back_channel_link_done_i) begin
              scl_oe_n_o <= 1'b1;
              if (!back_channel_link_nack_i) begin
                sda_oe_n_o <= 1'b0;
                state_r <= scr_pkg::S_ACK;
              end else begin
                state_r <= scr_pkg::S_IDLE;
              end
            end
          end
          scr_pkg::S_ACK, scr_pkg::S_HACK: begin
            if (ev.scl_rise) begin
              host_ack_r <= ~ev.sda;
            end else if (load_rd) begin
              cnt_r <= 4'h0;
              if (fwd_r) begin
                sda_oe_n_o <= 1'b1;
                back_channel_link_rd_o <= 1'b1;
                scl_oe_n_o <= 1'b0;
                state_r <= scr_pkg::S_FWD_RD;
              end else begin
                sh_r <= rd_data;
                sda_oe_n_o <= rd_data[7];
                idx_r <= idx_r + 8'h01;
                state_r <= scr_pkg::S_TX;
              end
            end else if (ev.scl_fall) begin
              sda_oe_n_o <= 1'b1;
              cnt_r <= 4'h0;
              state_r <= (state_r == scr_pkg::S_ACK) ? scr_pkg::S_RX : scr_pkg::S_IDLE;
            end
          end
          scr_pkg::S_FWD_RD: begin
            if (back_channel_link_done_i) begin
              scl_oe_n_o <= 1'b1;
              sh_r <= back_channel_link_rdata_i;
              sda_oe_n_o <= back_channel_link_rdata_i[7];
              state_r <= scr_pkg::S_TX;
            end
          end
          scr_pkg::S_TX: begin
            if (ev.scl_rise) begin
              cnt_r <= cnt_r + 4'h1;
            end else if (byte_end) begin
              sda_oe_n_o <= 1'b1;
              cnt_r <= 4'h0;
              state_r <= scr_pkg::S_HACK;
            end else if (ev.scl_fall) begin
              sh_r <= {sh_r[6:0], 1'b0};
              sda_oe_n_o <= sh_r[6];
            end
          end
        endcase
      end
    end
  end

  // Pins only ever drive low; the interrupt output is the inverse of the synced active-low input.
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
      downstream_irq_o <= 1'b0;
    end else begin
      scl_o <= 1'b0;
      sda_o <= 1'b0;
      downstream_irq_o <= ~irq_s_r[1];
    end
  end

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_addr_done;
    state_r == scr_pkg::S_ADDR && byte_end;
  endsequence

  a_strap_range: assert property (!regs_r[0][0] |-> own_addr inside {[7'h2C:7'h3B]})
    else $error("Strap address outside its range.");
  a_stop_release: assert property (ev.stop |=> state_r == scr_pkg::S_IDLE && sda_oe_n_o && scl_oe_n_o)
    else $error("STOP did not release the bus.");
  a_addr_ack: assert property (s_addr_done ##0 own_hit |=> !sda_oe_n_o ##1 (!sda_oe_n_o || ev.scl_fall || ev.stop))
    else $error("Own address not acknowledged.");
  a_addr_nack: assert property (s_addr_done ##0 (!own_hit && !alias_go) |=> sda_oe_n_o && state_r == scr_pkg::S_IDLE)
    else $error("Foreign address acknowledged.");
  a_write_ack: assert property (state_r == scr_pkg::S_RX && byte_end && !fwd_r |=> !sda_oe_n_o)
    else $error("Written byte not acknowledged.");
  a_host_nack: assert property (state_r == scr_pkg::S_HACK && ev.scl_fall && !host_ack_r
                                |=> sda_oe_n_o && state_r == scr_pkg::S_IDLE)
    else $error("Target kept SDA after host NACK.");
  a_pins_low: assert property (!scl_o && !sda_o)
    else $error("Pin output value not low.");
  a_stretch_hold: assert property (state_r inside {scr_pkg::S_FWD_ADDR, scr_pkg::S_FWD_WR, scr_pkg::S_FWD_RD}
                                   && !back_channel_link_done_i && !ev.stop |=> !scl_oe_n_o)
    else $error("SCL released while forwarding.");
  a_alias_swap: assert property (s_addr_done ##0 alias_go
                                 |=> back_channel_link_start_o && back_channel_link_addr_o == $past(alias_real))
    else $error("Alias not replaced by real address.");
  a_irq_follow: assert property ($fell(irq_s_r[1]) |=> downstream_irq_o)
    else $error("Downstream interrupt not passed on.");
  a_override: assert property (wr_en && idx_r == scr_pkg::REG_ID_IDX && sh_r[0]
                               |=> own_addr == $past(sh_r[7:1]))
    else $error("Override address not taken.");
  a_index_load: assert property (state_r == scr_pkg::S_RX && byte_end && !fwd_r && first_r
                                 |=> idx_r == $past(sh_r))
    else $error("First write byte did not set index.");

endmodule : scr_target

// ---- scr_host_model.sv ----
/*
  Bus host model for the serial control target: framing, bytes and acknowledges.
  Assumes the bench resolves the pulled-up lines and calls its tasks after a rising edge.
*/
`timescale 1ns/100ps
module scr_host_model (
  input wire logic sys_clk_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_rel_o,
  output logic sda_rel_o
);
  int stretch_cnt = 0;

  // Both lines start released; the host only ever pulls low or releases.
  initial begin
    scl_rel_o = 1'b1;
    sda_rel_o = 1'b1;
  end

  // Waits a third of a bit, well above the target's set-up need.
  task automatic q();
    repeat (10) @(posedge sys_clk_i);
  endtask : q

  // Releases SCL and waits, within a bound, while the target stretches it.
  task automatic rise();
    int n;
    n = 0;
    scl_rel_o <= 1'b1;
    @(posedge sys_clk_i);
    while (scl_i !== 1'b1 && n < 9000) begin
      @(posedge sys_clk_i);
      n++;
    end
    stretch_cnt += n;
    q();
  endtask : rise

  // Sends one bit and samples the line at the end of the high phase, just before SCL falls.
  task automatic bit_x(input logic b, output logic r);
    sda_rel_o <= b;
    q();
    rise();
    r = sda_i;
    scl_rel_o <= 1'b0;
    q();
  endtask : bit_x

  // Opens a frame; also serves as a repeated start.
  task automatic start();
    sda_rel_o <= 1'b1;
    q();
    rise();
    sda_rel_o <= 1'b0;
    q();
    scl_rel_o <= 1'b0;
    q();
  endtask : start

  // Closes a frame.
  task automatic stop();
    sda_rel_o <= 1'b0;
    q();
    rise();
    sda_rel_o <= 1'b1;
    q();
  endtask : stop

  // Writes a byte, most significant bit first; ack is high when the target pulled low.
  task automatic wr_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(d[i], r);
    end
    bit_x(1'b1, r);
    ack = ~r;
  endtask : wr_byte

  // Reads a byte, then acknowledges it unless it is the last one.
  task automatic rd_byte(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_x(1'b1, r);
      d[i] = r;
    end
    bit_x(last, r);
  endtask : rd_byte
endmodule : scr_host_model

// ---- scr_target_tb_top.sv ----
/*
  Self-checking bench for the serial control target with repeater forwarding.
  Assumes the design files and the host model are compiled before it.
*/
`timescale 1ns/100ps
module scr_target_tb_top;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] strap = 4'h0;
  logic rpt = 1'b0;
  logic irq_n = 1'b1;
  logic done = 1'b0;
  logic nk = 1'b0;
  logic [7:0] rdat = 8'h00;
  logic scl_o, scl_oe_n, sda_o, sda_oe_n, irq_o, lk_rnw, h_scl, h_sda;
  logic [3:0] lk;
  logic [6:0] lk_addr;
  logic [7:0] lk_wdata;
  logic [6:0] tab [11] = '{7'h2C, 7'h33, 7'h34, 7'h35, 7'h36, 7'h37, 7'h38, 7'h39, 7'h3A, 7'h3B, 7'h2C};
  int fails = 0;
  int cmp_count = 0;
  // Pulled-up lines: low when any party pulls low.
  wire scl_w = h_scl & (scl_oe_n | scl_o);
  wire sda_w = h_sda & (sda_oe_n | sda_o);

  // ----------------------------------------
  // Instances and clock
  // ----------------------------------------
  scr_target #(.REG_DEPTH(16), .NUM_ALIAS(4)) u_dut (
    .sys_clk_i(sys_clk), .rst_n_i(rst_n), .scl_i(scl_w), .scl_o(scl_o), .scl_oe_n_o(scl_oe_n),
    .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n_o(sda_oe_n), .address_strap_pin_i(strap),
    .repeat_mode_i(rpt), .downstream_irq_input_n_i(irq_n), .downstream_irq_o(irq_o),
    .back_channel_link_start_o(lk[0]), .back_channel_link_wr_o(lk[1]),
    .back_channel_link_rd_o(lk[2]), .back_channel_link_stop_o(lk[3]),
    .back_channel_link_addr_o(lk_addr), .back_channel_link_rnw_o(lk_rnw),
    .back_channel_link_wdata_o(lk_wdata), .back_channel_link_done_i(done),
    .back_channel_link_nack_i(nk), .back_channel_link_rdata_i(rdat));
  scr_host_model u_host (.sys_clk_i(sys_clk), .scl_i(scl_w), .sda_i(sda_w),
    .scl_rel_o(h_scl), .sda_rel_o(h_sda));

  // A 5 ns clock.
  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, msg, seen, exp);
    end
  endtask : chk

  task automatic end_of_test();
    $display("fails=%0d cmp_count=%0d", fails, cmp_count);
    if (fails == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test

  // Sends one write address byte and compares its acknowledge.
  task automatic probe(input logic [6:0] a, input logic exp);
    logic k;
    u_host.start();
    u_host.wr_byte({a, 1'b0}, k);
    chk({7'h0, k}, {7'h0, exp}, "address ack");
    u_host.stop();
  endtask : probe

  // Writes an index and then n bytes of dd, upper byte first.
  task automatic wr(input logic [6:0] a, input logic [7:0] idx, input logic [15:0] dd, input int n);
    logic k;
    u_host.start();
    u_host.wr_byte({a, 1'b0}, k);
    u_host.wr_byte(idx, k);
    chk({7'h0, k}, 8'h01, "index ack");
    for (int i = 0; i < n; i++) begin
      u_host.wr_byte(dd[15-8*i -: 8], k);
      chk({7'h0, k}, 8'h01, "data ack");
    end
    u_host.stop();
  endtask : wr

  // Sets an index, then reads n bytes after a repeated start.
  task automatic rd(input logic [6:0] a, input logic [7:0] idx, input int n, input logic [15:0] ex);
    logic k;
    logic [7:0] d;
    u_host.start();
    u_host.wr_byte({a, 1'b0}, k);
    u_host.wr_byte(idx, k);
    u_host.start();
    u_host.wr_byte({a, 1'b1}, k);
    for (int i = 0; i < n; i++) begin
      u_host.rd_byte(i == n - 1, d);
      chk(d, ex[15-8*i -: 8], "read data");
    end
    @(negedge sys_clk);
    chk({7'h0, sda_oe_n}, 8'h01, "released after nack");
    @(posedge sys_clk);
    u_host.stop();
  endtask : rd

  // Link partner: waits for pulse kd and answers it slowly unless it is the stop pulse; the read byte is then spoiled.
  task automatic lnk(input int kd, input logic [7:0] rb, input logic nack);
    int n;
    n = 0;
    while (lk[kd] !== 1'b1 && n < 9000) begin
      @(negedge sys_clk);
      n++;
    end
    chk({7'h0, lk[kd]}, 8'h01, "link pulse");
    if (kd != 3) begin
      repeat (20) @(posedge sys_clk);
      done <= 1'b1;
      nk <= nack;
      rdat <= rb;
      @(posedge sys_clk);
      done <= 1'b0;
      nk <= 1'b0;
      rdat <= ~rb;
    end
  endtask : lnk

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_strap();
    for (int s = 0; s < 11; s++) begin
      strap <= s[3:0];
      repeat (4) @(posedge sys_clk);
      probe(tab[s], 1'b1);
      probe(tab[s] ^ 7'h01, 1'b0);
    end
    strap <= 4'h0;
    repeat (4) @(posedge sys_clk);
  endtask : t_strap

  task automatic t_ovr();
    wr(7'h2C, 8'h00, 16'hAB00, 1);
    probe(7'h55, 1'b1);
    probe(7'h2C, 1'b0);
    wr(7'h55, 8'h00, 16'h0000, 1);
    probe(7'h2C, 1'b1);
  endtask : t_ovr

  task automatic t_alias();
    logic k;
    logic [7:0] d;
    int s0;
    wr(7'h2C, 8'h08, 16'hA044, 2);
    probe(7'h50, 1'b0);
    rpt <= 1'b1; // Strapped into repeater mode, a single level below us.
    s0 = u_host.stretch_cnt;
    fork
      begin
        u_host.start();
        u_host.wr_byte(8'hA0, k);
        chk({7'h0, k}, 8'h01, "alias ack");
        u_host.wr_byte(8'h77, k);
        chk({7'h0, k}, 8'h01, "forward write ack");
        u_host.start();
        u_host.wr_byte(8'hA1, k);
        u_host.rd_byte(1'b1, d);
        chk(d, 8'h9C, "forward read data");
        u_host.stop();
      end
      begin
        lnk(0, 8'h00, 1'b0);
        chk({1'b0, lk_addr}, 8'h22, "real address");
        chk({7'h0, lk_addr != 7'h2C}, 8'h01, "distinct address");
        lnk(1, 8'h00, 1'b0);
        chk(lk_wdata, 8'h77, "forward wdata");
        lnk(0, 8'h00, 1'b0);
        chk({7'h0, lk_rnw}, 8'h01, "forward direction");
        lnk(2, 8'h9C, 1'b0);
        lnk(3, 8'h00, 1'b0);
      end
    join
    chk({7'h0, u_host.stretch_cnt > s0}, 8'h01, "clock stretched");
    fork
      probe(7'h50, 1'b0);
      lnk(0, 8'h00, 1'b1);
    join
    rpt <= 1'b0;
  endtask : t_alias

  task automatic t_irq();
    irq_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    chk({7'h0, irq_o}, 8'h01, "irq raised");
    @(posedge sys_clk);
    irq_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    @(negedge sys_clk);
    chk({7'h0, irq_o}, 8'h00, "irq cleared");
  endtask : t_irq

  // ----------------------------------------
  // Sequence, monitor and watchdog
  // ----------------------------------------
  // Target output values may never be high, as the pins only pull low.
  always @(negedge sys_clk) begin
    if (rst_n === 1'b1) begin
      chk({6'h0, scl_o, sda_o}, 8'h00, "drives high");
    end
  end

  // Main sequence: reset, then every scenario in turn.
  initial begin
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk);
    chk({6'h0, scl_oe_n, sda_oe_n}, 8'h03, "reset idle");
    @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    t_strap();
    wr(7'h2C, 8'h03, 16'hA53C, 2);
    rd(7'h2C, 8'h03, 2, 16'hA53C);
    rd(7'h2C, 8'h00, 1, 16'h5800);
    t_ovr();
    t_alias();
    t_irq();
    end_of_test();
  end

  // Cuts a hang short well past the expected run length.
  initial begin
    repeat (80000) @(posedge sys_clk);
    fails++;
    end_of_test();
  end
endmodule : scr_target_tb_top
